// [rtl/htb_params.svh]
// Purpose: Constants of the host transmit buffer port
// Assumes: Included by every design file that needs them
// Notes: Offsets are byte addresses on the register bus
//
// Functional notes
// - Internal control word: flag bit7, limit 4:0
// - Flag low: core owns; high: host writes
// - Flag mirrored to status and DMA request
// - Reset clears the handoff flag
// - Core setting flag clears address counter
// - Upper byte access increments address counter
// - Eight-bit port, address bit0 picks byte
// - DMA: acknowledge selects, toggle picks byte
// - Flag rising clears the transmit toggle
// - Counter equals limit: flag clears automatically
// - Core loads limit and flag together
// - Core reads buffer after flag clears
// - DMA request follows the handoff flag
// - One or two 8-bit DMA controllers
// - Fly-by: acknowledge plus strobe selects device
// - Flow-through: acknowledge high, normal decode
// - Toggle advances at end of DMA cycle
`ifndef HTB_PARAMS_SVH
`define HTB_PARAMS_SVH

// ============================================================
// Register map
`define HTB_OFS_CTRL 32'h0000_0000
`define HTB_OFS_STATUS 32'h0000_0004
`define HTB_OFS_BUF_LO 32'h0000_0040
`define HTB_OFS_BUF_HI 32'h0000_007C
`define HTB_BUF_IDX_MSB 5
`define HTB_BUF_IDX_LSB 2

// ============================================================
// Control word fields
`define HTB_FLAG_BIT 7
`define HTB_LIMIT_MSB 4
`define HTB_LIMIT_LSB 0
`define HTB_CTRL_RESET 16'h0000
`define HTB_STAT_TOGGLE_BIT 6
`define HTB_STAT_CTR_MSB 5
`define HTB_STAT_CTR_LSB 1
`define HTB_STAT_FLAG_BIT 0

// ============================================================
// Host side
`define HTB_TX_PORT_WORD 3'h0
`define HTB_CTR_ONE 5'h01
`define HTB_CTR_ZERO 5'h00
`define HTB_PORT_SEL_MSB 3
`define HTB_PORT_SEL_LSB 1
`define HTB_BYTE_SEL_BIT 0
`define HTB_BUF_WORDS 16
`define HTB_HTRANS_NONSEQ_BIT 1

`endif

// [rtl/htb_pkg.sv]
// Purpose: Types of the host transmit buffer port
// Assumes: Nothing
// Notes: Constants live in htb_params.svh
package htb_pkg;

    // ========================================================
    // Host pins, sampled as one group
    typedef struct packed {
        logic host_chip_select_n;
        logic host_write_strobe_n;
        logic host_read_strobe_n;
        logic tx_dma_ack_n;
        logic [3:0] host_port_address_lines;
        logic [7:0] hostData;
    } htb_host_s;

    // ========================================================
    // Internal control word
    typedef struct packed {
        logic [7:0] zeroHi;
        logic handoff;
        logic [1:0] zeroMid;
        logic [4:0] limit;
    } htb_ctrl_s;

    // ========================================================
    // Register bus sequencing
    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_RDWAIT
    } htb_bus_e;

endpackage : htb_pkg

// [rtl/htb_sync_stage.sv]
// Purpose: Two-flop register stage for host pin groups
// Assumes: Inputs synchronous to clk, held across strobes
// Notes: First flop feeds only the second
`timescale 1ns/1ps
module htb_sync_stage #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    // ========================================================
    // Stages
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage1 <= INIT;
            q <= INIT;
        end else if (ce) begin
            stage1 <= d;
            q <= stage1;
        end
    end

endmodule : htb_sync_stage

// [rtl/htb_tx_port.sv]
// Purpose: Host transmit buffer with handoff flag and DMA
// Assumes: AHB-Lite slave for core access, host pins sync
// Notes: Single clock domain, zero-wait writes
`timescale 1ns/1ps
`include "htb_params.svh"
module htb_tx_port (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire htb_pkg::htb_host_s hostPins,
    output logic tx_dma_request,
    output logic hostStatusReady
);

    // ========================================================
    // Declarations
    htb_pkg::htb_host_s hostQ;
    htb_pkg::htb_host_s hostD;
    htb_pkg::htb_ctrl_s ctrl;
    htb_pkg::htb_bus_e busState;
    logic [15:0] txMem [`HTB_BUF_WORDS];
    logic [4:0] addrCtr;
    logic dmaToggle;
    logic wrPend;
    logic [31:0] addrQ;
    logic [31:0] rdMux;
    logic wrRise;
    logic procSel;
    logic dmaSel;
    logic accEvt;
    logic byteSel;
    logic upperAcc;
    logic [4:0] next_addrCtr;
    logic ctrlWr;
    logic addrPhase;
    logic [3:0] wIdx;

    // ========================================================
    // Host pin registering
    htb_sync_stage #(
        .WIDTH($bits(htb_pkg::htb_host_s)),
        .INIT('1)
    ) htb_sync_stage_i (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .d(hostPins),
        .q(hostQ)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hostD <= '1;
        end else if (ce) begin
            hostD <= hostQ;
        end
    end

    // ========================================================
    // Access decode, taken at the strobe's rising edge
    assign wrRise = !hostD.host_write_strobe_n && hostQ.host_write_strobe_n;
    assign dmaSel = !hostD.tx_dma_ack_n;
    assign procSel = hostD.tx_dma_ack_n && !hostD.host_chip_select_n &&
        (hostD.host_port_address_lines[`HTB_PORT_SEL_MSB:`HTB_PORT_SEL_LSB]
        == `HTB_TX_PORT_WORD);
    assign accEvt = wrRise && (procSel || dmaSel) && ctrl.handoff;
    assign byteSel = dmaSel ? dmaToggle
        : hostD.host_port_address_lines[`HTB_BYTE_SEL_BIT];
    assign upperAcc = accEvt && byteSel;
    assign next_addrCtr = addrCtr + `HTB_CTR_ONE;
    assign wIdx = addrCtr[3:0];

    // ========================================================
    // Register bus phases
    assign addrPhase = hsel && htrans[`HTB_HTRANS_NONSEQ_BIT] && hready;
    assign ctrlWr = wrPend && (addrQ == `HTB_OFS_CTRL);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPend <= 1'b0;
            addrQ <= 32'h0000_0000;
        end else if (ce) begin
            wrPend <= addrPhase && hwrite;
            if (addrPhase) begin
                addrQ <= haddr;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busState <= htb_pkg::BUS_IDLE;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
        end else if (ce) begin
            case (busState)
                htb_pkg::BUS_IDLE: begin
                    if (addrPhase && !hwrite) begin
                        busState <= htb_pkg::BUS_RDWAIT;
                        hreadyout <= 1'b0;
                    end
                end
                htb_pkg::BUS_RDWAIT: begin
                    hrdata <= rdMux;
                    hreadyout <= 1'b1;
                    busState <= htb_pkg::BUS_IDLE;
                end
                default: begin
                    busState <= htb_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hresp <= 1'b0;
        end else if (ce) begin
            hresp <= 1'b0;
        end
    end

    // ========================================================
    // Read data mux
    always_comb begin
        rdMux = 32'h0000_0000;
        if (addrQ == `HTB_OFS_CTRL) begin
            rdMux = {16'h0000, ctrl};
        end else if (addrQ == `HTB_OFS_STATUS) begin
            rdMux[`HTB_STAT_TOGGLE_BIT] = dmaToggle;
            rdMux[`HTB_STAT_CTR_MSB:`HTB_STAT_CTR_LSB] = addrCtr;
            rdMux[`HTB_STAT_FLAG_BIT] = ctrl.handoff;
        end else if (addrQ >= `HTB_OFS_BUF_LO &&
            addrQ <= `HTB_OFS_BUF_HI && !ctrl.handoff) begin
            rdMux = {16'h0000,
                txMem[addrQ[`HTB_BUF_IDX_MSB:`HTB_BUF_IDX_LSB]]};
        end
    end

    // ========================================================
    // Control word and handoff flag
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl <= `HTB_CTRL_RESET;
        end else if (ce) begin
            if (ctrlWr && !ctrl.handoff) begin
                ctrl.handoff <= hwdata[`HTB_FLAG_BIT];
                ctrl.limit <= hwdata[`HTB_LIMIT_MSB:`HTB_LIMIT_LSB];
            end else if (upperAcc && next_addrCtr == ctrl.limit) begin
                ctrl.handoff <= 1'b0;
            end
            ctrl.zeroHi <= 8'h00;
            ctrl.zeroMid <= 2'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_dma_request <= 1'b0;
            hostStatusReady <= 1'b0;
        end else if (ce) begin
            if (ctrlWr && !ctrl.handoff) begin
                tx_dma_request <= hwdata[`HTB_FLAG_BIT];
                hostStatusReady <= hwdata[`HTB_FLAG_BIT];
            end else if (upperAcc && next_addrCtr == ctrl.limit) begin
                tx_dma_request <= 1'b0;
                hostStatusReady <= 1'b0;
            end
        end
    end

    // ========================================================
    // Address counter and DMA byte toggle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addrCtr <= `HTB_CTR_ZERO;
        end else if (ce) begin
            if (ctrlWr && !ctrl.handoff && hwdata[`HTB_FLAG_BIT]) begin
                addrCtr <= `HTB_CTR_ZERO;
            end else if (upperAcc) begin
                addrCtr <= next_addrCtr;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dmaToggle <= 1'b0;
        end else if (ce) begin
            if (ctrlWr && !ctrl.handoff && hwdata[`HTB_FLAG_BIT]) begin
                dmaToggle <= 1'b0;
            end else if (accEvt && dmaSel) begin
                dmaToggle <= !dmaToggle;
            end
        end
    end

    // ========================================================
    // Buffer storage
    always_ff @(posedge clk) begin
        if (ce && accEvt) begin
            if (byteSel) begin
                txMem[wIdx][15:8] <= hostD.hostData;
            end else begin
                txMem[wIdx][7:0] <= hostD.hostData;
            end
        end
    end

    // ========================================================
    // Checks
    property p_reset_flag;
        @(posedge clk) sys_rst |=> !ctrl.handoff && !tx_dma_request;
    endproperty
    a_reset_flag: assert property (p_reset_flag)
        else $error("flag not cleared by reset");

    property p_arm_clears;
        @(posedge clk) disable iff (sys_rst)
        ce && ctrlWr && !ctrl.handoff && hwdata[`HTB_FLAG_BIT]
        |=> addrCtr == 5'h00 && ctrl.handoff && tx_dma_request;
    endproperty
    a_arm_clears: assert property (p_arm_clears)
        else $error("arming did not clear counter");

    property p_toggle_zero;
        @(posedge clk) disable iff (sys_rst)
        $rose(ctrl.handoff) |-> !dmaToggle && hostStatusReady;
    endproperty
    a_toggle_zero: assert property (p_toggle_zero)
        else $error("toggle not zero at handoff");

    property p_ctr_inc;
        @(posedge clk) disable iff (sys_rst)
        ce && upperAcc |=> addrCtr == $past(next_addrCtr);
    endproperty
    a_ctr_inc: assert property (p_ctr_inc)
        else $error("counter did not advance");

    property p_auto_clear;
        @(posedge clk) disable iff (sys_rst)
        ce && upperAcc && next_addrCtr == ctrl.limit
        |=> !ctrl.handoff && !tx_dma_request && !hostStatusReady;
    endproperty
    a_auto_clear: assert property (p_auto_clear)
        else $error("flag not cleared at limit");

    property p_ignore_idle;
        @(posedge clk) disable iff (sys_rst)
        ce && wrRise && !ctrl.handoff && !ctrlWr
        |=> addrCtr == $past(addrCtr) && dmaToggle == $past(dmaToggle);
    endproperty
    a_ignore_idle: assert property (p_ignore_idle)
        else $error("write accepted while core owns buffer");

    property p_dma_toggle;
        @(posedge clk) disable iff (sys_rst)
        ce && accEvt && dmaSel |=> dmaToggle != $past(dmaToggle);
    endproperty
    a_dma_toggle: assert property (p_dma_toggle)
        else $error("dma toggle did not flip");

    property p_low_byte;
        @(posedge clk) disable iff (sys_rst)
        ce && accEvt && !byteSel
        |=> txMem[$past(wIdx)][7:0] == $past(hostD.hostData);
    endproperty
    a_low_byte: assert property (p_low_byte)
        else $error("low byte not stored");

    property p_hi_byte;
        @(posedge clk) disable iff (sys_rst)
        ce && accEvt && byteSel
        |=> txMem[$past(wIdx)][15:8] == $past(hostD.hostData);
    endproperty
    a_hi_byte: assert property (p_hi_byte)
        else $error("high byte not stored");

    property p_flag_mirror;
        @(posedge clk) disable iff (sys_rst)
        tx_dma_request == ctrl.handoff && hostStatusReady == ctrl.handoff;
    endproperty
    a_flag_mirror: assert property (p_flag_mirror)
        else $error("status or request differs from flag");

    property p_ctr_frozen;
        @(posedge clk) disable iff (sys_rst)
        ce && !ctrl.handoff && !ctrlWr |=> addrCtr == $past(addrCtr);
    endproperty
    a_ctr_frozen: assert property (p_ctr_frozen)
        else $error("counter moved while core owns buffer");

    property p_ctrl_locked;
        @(posedge clk) disable iff (sys_rst)
        ce && ctrlWr && ctrl.handoff && !upperAcc
        |=> ctrl.limit == $past(ctrl.limit) && ctrl.handoff;
    endproperty
    a_ctrl_locked: assert property (p_ctrl_locked)
        else $error("control changed while host owns buffer");

endmodule : htb_tx_port

// [bench/htb_host_model.sv]
// Purpose: Host processor and 8-bit DMA controller on the host pins
// Assumes: Pins change just after a rising clk edge
// Notes: Released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module htb_host_model (
    input wire logic clk,
    output htb_pkg::htb_host_s pins
);
    // ============================================================
    // Idle pins
    initial begin
        pins = '1;
    end

    // ============================================================
    // One byte write: processor cycle or fly-by DMA cycle
    task automatic put(input logic dma, input logic a0,
        input logic [7:0] d);
        logic [3:0] a;
        a = dma ? 4'hB : {3'h0, a0};
        pins.host_chip_select_n <= dma;
        pins.tx_dma_ack_n <= ~dma;
        pins.host_port_address_lines <= a;
        pins.hostData <= d;
        pins.host_write_strobe_n <= 1'b0;
        repeat (2) @(posedge clk);
        pins.host_write_strobe_n <= 1'b1;
        @(posedge clk);
        pins.host_chip_select_n <= 1'b1;
        pins.tx_dma_ack_n <= 1'b1;
        pins.host_port_address_lines <= ~a;
        pins.hostData <= ~d;
        repeat (4) @(posedge clk);
    endtask : put
endmodule : htb_host_model

// [bench/htb_tx_port_tb.sv]
// Purpose: Self-checking bench of the host transmit buffer port
// Assumes: One AHB-Lite slave, hready tied to hreadyout
// Notes: Host pins come from the host model
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
    checked++; \
    if ((g) !== (e)) begin \
        errTotal++; \
        $display("MISMATCH %s exp %h got %h", n, e, g); \
    end \
end
module host_tx_buffer_dma_port_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    htb_pkg::htb_host_s hostPins;
    logic txReq;
    logic statusReady;
    int errTotal = 0;
    int checked = 0;

    always #20 clk = ~clk;

    htb_tx_port htb_tx_port_i (.clk(clk), .sys_rst(sys_rst), .ce(1'b1),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .hostPins(hostPins), .tx_dma_request(txReq),
        .hostStatusReady(statusReady));

    htb_host_model htb_host_model_i (.clk(clk), .pins(hostPins));

    // ============================================================
    // Bus tasks
    task automatic bus(input logic w, input logic [31:0] a,
        input logic [31:0] d, output logic [31:0] q);
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        `CHK("hrdata", e, q)
    endtask : rd

    task automatic flags(input logic e);
        @(negedge clk);
        `CHK("tx_dma_request", e, txReq)
        `CHK("hostStatusReady", e, statusReady)
        @(posedge clk);
    endtask : flags

    // ============================================================
    // Scenarios
    task automatic t_reset();
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        `CHK("hreadyout", 1'b1, hreadyout)
        `CHK("hresp", 1'b0, hresp)
        @(posedge clk);
        flags(1'b0);
        rd(32'h0, 32'h0);
        rd(32'h4, 32'h0);
        rd(32'h20, 32'h0);
    endtask : t_reset

    task automatic t_ignored();
        htb_host_model_i.put(1'b0, 1'b0, 8'h11);
        htb_host_model_i.put(1'b0, 1'b1, 8'h22);
        htb_host_model_i.put(1'b1, 1'b0, 8'h33);
        rd(32'h4, 32'h0);
    endtask : t_ignored

    task automatic t_cpu();
        wr(32'h0, 32'hFFFF_FFE2);
        flags(1'b1);
        rd(32'h0, 32'h82);
        rd(32'h4, 32'h1);
        htb_host_model_i.put(1'b0, 1'b0, 8'h34);
        htb_host_model_i.put(1'b0, 1'b1, 8'h12);
        rd(32'h4, 32'h3);
        rd(32'h40, 32'h0);
        wr(32'h0, 32'h0);
        rd(32'h0, 32'h82);
        htb_host_model_i.put(1'b0, 1'b0, 8'h78);
        htb_host_model_i.put(1'b0, 1'b1, 8'h56);
        flags(1'b0);
        rd(32'h4, 32'h4);
        rd(32'h0, 32'h2);
        rd(32'h40, 32'h1234);
        rd(32'h44, 32'h5678);
    endtask : t_cpu

    task automatic t_dma();
        wr(32'h0, 32'h81);
        htb_host_model_i.put(1'b1, 1'b0, 8'hAB);
        rd(32'h4, 32'h41);
        htb_host_model_i.put(1'b0, 1'b1, 8'hCD);
        rd(32'h4, 32'h42);
        rd(32'h40, 32'hCDAB);
        wr(32'h0, 32'h82);
        rd(32'h4, 32'h1);
        htb_host_model_i.put(1'b1, 1'b0, 8'hEF);
        htb_host_model_i.put(1'b1, 1'b0, 8'h01);
        rd(32'h4, 32'h3);
        htb_host_model_i.put(1'b1, 1'b0, 8'h23);
        htb_host_model_i.put(1'b1, 1'b0, 8'h45);
        flags(1'b0);
        rd(32'h4, 32'h4);
        rd(32'h40, 32'h01EF);
        rd(32'h44, 32'h4523);
    endtask : t_dma

    task automatic t_rerun();
        wr(32'h0, 32'h83);
        htb_host_model_i.put(1'b1, 1'b0, 8'h9A);
        rd(32'h4, 32'h41);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        flags(1'b0);
        rd(32'h4, 32'h0);
        rd(32'h0, 32'h0);
    endtask : t_rerun

    // ============================================================
    // Verdict
    task automatic testDone();
        $display("Checks %0d, mismatches %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : testDone

    initial begin
        t_reset();
        t_ignored();
        t_cpu();
        t_dma();
        t_rerun();
        testDone();
    end

    initial begin
        repeat (20000) @(posedge clk);
        errTotal++;
        testDone();
    end
endmodule : host_tx_buffer_dma_port_tb
